// ==== rtl/flash_status_map.svh ====
// Constants of the serial flash status and write-enable block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef FLASH_STATUS_MAP_SVH
`define FLASH_STATUS_MAP_SVH

// Status byte field positions
`define STAT_BUSY_BIT        0
`define STAT_LATCH_BIT       1
`define STAT_BP_LSB          2
`define STAT_BP_MSB          5
`define STAT_QE_BIT          6
`define STAT_LOCK_BIT        7
`define STAT_RESET           8'h00
`define NV_FACTORY           6'h00
// Protect, quad-enable and lock positions inside the stored six bits
`define NV_BP_MSB            3
`define NV_QE_BIT            4
`define NV_LOCK_BIT          5

// Opcodes used outside the class decoder
`define OP_LATCH_SET         8'h06
`define OP_STATUS_WRITE      8'h01
`define OP_SUSPEND           8'h75
`define OP_CHIP_ERASE_A      8'hc7
`define OP_CHIP_ERASE_B      8'h60
`define OP_READ_PARAM_VOL    8'hc0
`define OP_BANK_ADDR_VOL     8'h17

// Deep power-down parameter word
`define DPD_EXIT_OP          8'hab
`define DPD_ENTER_OP         8'hb9
`define DPD_EXIT_LSB         15
`define DPD_ENTER_LSB        23

// Pin reset levels: chip select, clock, data, protect
`define PIN_RESET            4'h9

`endif

// ==== rtl/flash_status_pkg.sv ====
// Types and opcode decoding of the status and write-enable block.
// Assumes the map header sits beside it.
package flash_status_pkg;
`include "flash_status_map.svh"

    typedef enum logic [2:0] {
        OPC_NONE  = 3'h0,
        OPC_PROG  = 3'h1,
        OPC_ERASE = 3'h2,
        OPC_NVREG = 3'h3,
        OPC_VREG  = 3'h4
    } op_class_type;

    typedef enum logic [5:0] {
        ST_POWERUP = 6'h01,
        ST_IDLE    = 6'h02,
        ST_OPCODE  = 6'h04,
        ST_WDATA   = 6'h08,
        ST_RDOUT   = 6'h10,
        ST_SINK    = 6'h20
    } frame_state_type;

    // Every class other than none needs the write latch
    function automatic op_class_type op_class(input logic [7:0] op);
        case (op)
            8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3e, 8'h62:
                return OPC_PROG;
            8'hd7, 8'h20, 8'h21, 8'h52, 8'h5c, 8'hd8, 8'hdc, 8'h64,
            `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B:
                return OPC_ERASE;
            `OP_STATUS_WRITE, 8'h42, 8'h65, 8'h85, 8'h15, 8'h18, 8'hfd, 8'he3,
            8'he4, 8'h2f, 8'ha6, 8'he8, 8'h7e, 8'h98:
                return OPC_NVREG;
            8'h83, 8'hfb, 8'he1, 8'h91:
                return OPC_VREG;
            default:
                return OPC_NONE;
        endcase
    endfunction : op_class

    function automatic logic is_chip_erase(input logic [7:0] op);
        return (op == `OP_CHIP_ERASE_A) || (op == `OP_CHIP_ERASE_B);
    endfunction : is_chip_erase

endpackage : flash_status_pkg

// ==== rtl/flash_status_write_enable.sv ====
// Status byte and write-enable gating of a serial flash, behind its serial pins.
// Assumes mode 0 framing and a serial clock well below an eighth of mclk.
`timescale 1ns/1ns
`default_nettype none
`include "flash_status_map.svh"

module flash_status_write_enable #(
    parameter int         TIMER_W         = 16,
    parameter int         PROG_CYCLES     = 1000,
    parameter int         ERASE_CYCLES    = 4000,
    parameter int         NVREG_CYCLES    = 500,
    parameter logic [7:0] STATUS_READ_OP  = 8'h05,
    parameter logic [7:0] LATCH_CLEAR_OP  = 8'h04,
    parameter logic [7:0] RESUME_OP       = 8'h7a,
    parameter logic [7:0] RESET_ARM_OP    = 8'h66,
    parameter logic [7:0] RESET_OP        = 8'h99
) (
    // Clock and reset
    input  wire logic                         mclk,
    input  wire logic                         rst_b,
    // Serial pins
    input  wire logic                         ce_b,
    input  wire logic                         sck,
    input  wire logic                         si,
    input  wire logic                         wp_b,
    output var  logic                         so,
    output var  logic                         so_oe,
    // Array side
    output var  logic                         op_start,
    output var  flash_status_pkg::op_class_type op_kind,
    output var  logic                         op_suspended,
    // Status view
    output var  logic [7:0]                   status_byte,
    output var  logic                         quad_pin_enable,
    output var  logic [3:0]                   block_protect,
    output var  logic [31:0]                  dpd_param_word
);
    import flash_status_pkg::*;

    typedef struct packed {
        frame_state_type st;
        logic            sck_prev;
        logic [7:0]      shift;
        logic [2:0]      bitcnt;
        logic [7:0]      opcode;
        logic [7:0]      wdata;
        logic            wdata_ok;
        logic [7:0]      out_byte;
        logic            so;
        logic            so_oe;
        logic            write_latch_flag;
        logic [5:0]      vol;
        logic [5:0]      nv;
        logic            wel_clear_pend;
        logic            suspended;
        logic            reset_armed;
        logic            tmr_load;
        logic            tmr_abort;
        op_class_type    kind;
        logic            op_start;
    } state_type;

    state_type        q_reg;
    state_type        q_next;
    logic [3:0]       pins_s;
    logic             ce_s;
    logic             sck_s;
    logic             si_s;
    logic             wp_s;
    logic             sck_rise;
    logic             sck_fall;
    logic             tmr_busy;
    logic             tmr_done;
    logic             busy_now;
    logic             exec_now;
    logic [7:0]       status_now;
    logic [7:0]       shifted;
    logic [TIMER_W-1:0] tmr_value;
    op_class_type     cls;

    if (TIMER_W < 2 || PROG_CYCLES < 1 || ERASE_CYCLES < 1 || NVREG_CYCLES < 1 ||
        PROG_CYCLES >= 2**TIMER_W || ERASE_CYCLES >= 2**TIMER_W ||
        NVREG_CYCLES >= 2**TIMER_W) begin : bad_cfg
        $error("operation counts must be at least one and fit the timer");
    end

    pin_sync #(
        .WIDTH     (4),
        .RESET_VAL (`PIN_RESET)
    ) pin_sync_i (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .pin_in   ({ce_b, sck, si, wp_b}),
        .sync_out (pins_s)
    );

    op_timer #(
        .W (TIMER_W)
    ) op_timer_i (
        .mclk       (mclk),
        .rst_b      (rst_b),
        .load       (q_reg.tmr_load),
        .load_value (tmr_value),
        .pause      (q_reg.suspended),
        .abort      (q_reg.tmr_abort),
        .busy       (tmr_busy),
        .done       (tmr_done)
    );

    assign ce_s     = pins_s[3];
    assign sck_s    = pins_s[2];
    assign si_s     = pins_s[1];
    assign wp_s     = pins_s[0];
    assign sck_rise = sck_s && !q_reg.sck_prev;
    assign sck_fall = !sck_s && q_reg.sck_prev;
    assign shifted  = {q_reg.shift[6:0], si_s};
    assign cls      = op_class(q_reg.opcode);
    // Suspended work reads as ready so the host may issue other reads
    assign busy_now = tmr_busy && !q_reg.suspended;
    // Instructions act only at chip-select release after a whole opcode
    assign exec_now = ce_s && (q_reg.st == ST_WDATA || q_reg.st == ST_RDOUT ||
                               q_reg.st == ST_SINK);
    assign status_now = {q_reg.vol, q_reg.write_latch_flag, busy_now};

    always_comb begin
        unique case (q_reg.kind)
            OPC_PROG:  tmr_value = TIMER_W'(PROG_CYCLES);
            OPC_ERASE: tmr_value = TIMER_W'(ERASE_CYCLES);
            OPC_NVREG: tmr_value = TIMER_W'(NVREG_CYCLES);
            default:   tmr_value = TIMER_W'(1);
        endcase
    end

    always_comb begin
        q_next           = q_reg;
        q_next.sck_prev  = sck_s;
        q_next.tmr_load  = 1'b0;
        q_next.tmr_abort = 1'b0;
        q_next.op_start  = 1'b0;

        if (tmr_done) begin
            q_next.wel_clear_pend = 1'b0;
            if (q_reg.wel_clear_pend) begin
                q_next.write_latch_flag = 1'b0;
            end
        end

        unique case (q_reg.st)
            ST_POWERUP: begin
                q_next.vol = q_reg.nv;
                q_next.st  = ST_IDLE;
            end
            ST_IDLE: begin
                if (!ce_s) begin
                    q_next.st     = ST_OPCODE;
                    q_next.bitcnt = 3'h0;
                end
            end
            ST_OPCODE: begin
                if (ce_s) begin
                    q_next.st = ST_IDLE;
                end else if (sck_rise) begin
                    q_next.shift  = shifted;
                    q_next.bitcnt = q_reg.bitcnt + 3'h1;
                    if (q_reg.bitcnt == 3'h7) begin
                        q_next.opcode   = shifted;
                        q_next.out_byte = status_now;
                        q_next.wdata_ok = 1'b0;
                        if (shifted == STATUS_READ_OP) begin
                            q_next.st = ST_RDOUT;
                        end else if (shifted == `OP_STATUS_WRITE) begin
                            q_next.st = ST_WDATA;
                        end else begin
                            q_next.st = ST_SINK;
                        end
                    end
                end
            end
            ST_WDATA: begin
                // Bytes after the first are dropped
                if (sck_rise && !q_reg.wdata_ok) begin
                    q_next.shift  = shifted;
                    q_next.bitcnt = q_reg.bitcnt + 3'h1;
                    if (q_reg.bitcnt == 3'h7) begin
                        q_next.wdata    = shifted;
                        q_next.wdata_ok = 1'b1;
                    end
                end
            end
            ST_RDOUT: begin
                // Byte latched once per frame and replayed
                if (sck_fall) begin
                    q_next.so     = q_reg.out_byte[3'h7 - q_reg.bitcnt];
                    q_next.so_oe  = 1'b1;
                    q_next.bitcnt = q_reg.bitcnt + 3'h1;
                end
            end
            ST_SINK: begin
            end
        endcase

        if (exec_now) begin
            q_next.st          = ST_IDLE;
            q_next.so_oe       = 1'b0;
            q_next.so          = 1'b0;
            q_next.reset_armed = (q_reg.opcode == RESET_ARM_OP);
            if (q_reg.reset_armed && q_reg.opcode == RESET_OP) begin
                q_next.tmr_abort      = 1'b1;
                q_next.write_latch_flag            = 1'b0;
                q_next.wel_clear_pend = 1'b0;
                q_next.suspended      = 1'b0;
                q_next.vol            = q_reg.nv;
            end else if (busy_now) begin
                if (q_reg.opcode == `OP_SUSPEND &&
                    (q_reg.kind == OPC_PROG || q_reg.kind == OPC_ERASE)) begin
                    q_next.suspended = 1'b1;
                end
            end else if (q_reg.opcode == `OP_LATCH_SET) begin
                q_next.write_latch_flag = 1'b1;
            end else if (q_reg.opcode == LATCH_CLEAR_OP) begin
                q_next.write_latch_flag = 1'b0;
            end else if (q_reg.suspended) begin
                if (q_reg.opcode == RESUME_OP) begin
                    q_next.suspended = 1'b0;
                end
            end else if (q_reg.opcode == `OP_READ_PARAM_VOL ||
                         q_reg.opcode == `OP_BANK_ADDR_VOL) begin
                q_next.kind     = OPC_VREG;
                q_next.op_start = 1'b1;
            end else if (cls != OPC_NONE && q_reg.write_latch_flag) begin
                if (q_reg.opcode == `OP_STATUS_WRITE) begin
                    // Lock binds only while the protect pin still has its role
                    if (q_reg.wdata_ok && !(q_reg.vol[`NV_LOCK_BIT] && !wp_s &&
                                            !q_reg.vol[`NV_QE_BIT])) begin
                        q_next.vol = q_reg.wdata[`STAT_LOCK_BIT:`STAT_BP_LSB];
                        q_next.nv  = q_reg.wdata[`STAT_LOCK_BIT:`STAT_BP_LSB];
                        q_next.kind           = OPC_NVREG;
                        q_next.op_start       = 1'b1;
                        q_next.tmr_load       = 1'b1;
                        q_next.wel_clear_pend = 1'b1;
                    end
                end else if (!(is_chip_erase(q_reg.opcode) &&
                               q_reg.vol[`NV_BP_MSB:0] != 4'h0)) begin
                    q_next.kind           = cls;
                    q_next.op_start       = 1'b1;
                    q_next.tmr_load       = (cls != OPC_VREG);
                    q_next.wel_clear_pend = (cls != OPC_VREG);
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            q_reg     <= '0;
            q_reg.st  <= ST_POWERUP;
            q_reg.nv  <= `NV_FACTORY;
            q_reg.vol <= `NV_FACTORY;
        end else begin
            q_reg <= q_next;
        end
    end

    assign so              = q_reg.so;
    assign so_oe           = q_reg.so_oe;
    assign op_start        = q_reg.op_start;
    assign op_kind         = q_reg.kind;
    assign op_suspended    = q_reg.suspended;
    assign status_byte     = status_now;
    assign quad_pin_enable = q_reg.vol[`NV_QE_BIT];
    assign block_protect   = q_reg.vol[`NV_BP_MSB:0];
    assign dpd_param_word  = (32'(`DPD_ENTER_OP) << `DPD_ENTER_LSB) |
                             (32'(`DPD_EXIT_OP) << `DPD_EXIT_LSB);

    // Checks
    logic out_bit_sel;
    assign out_bit_sel = q_reg.out_byte[3'h7 - q_reg.bitcnt];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    read_repeat_a: assert property (
        (q_reg.st == ST_RDOUT && sck_fall && !ce_s) |=>
            (q_reg.so == $past(out_bit_sel)) && $stable(q_reg.out_byte))
        else $error("status read bit or byte changed");

    powerup_load_a: assert property (
        (q_reg.st == ST_POWERUP) |=> (q_reg.vol == $past(q_reg.nv)))
        else $error("working copy not loaded at power-up");

    busy_raise_a: assert property (
        q_reg.tmr_load |=> status_byte[`STAT_BUSY_BIT] [*2])
        else $error("busy not raised after operation start");

    busy_ignore_a: assert property (
        (exec_now && busy_now && q_reg.opcode == `OP_LATCH_SET) |=> $stable(q_reg.write_latch_flag))
        else $error("latch changed while busy");

    suspend_take_a: assert property (
        (exec_now && busy_now && q_reg.opcode == `OP_SUSPEND &&
         (q_reg.kind == OPC_PROG || q_reg.kind == OPC_ERASE)) |=>
            q_reg.suspended && !status_byte[`STAT_BUSY_BIT])
        else $error("suspend not taken during program or erase");

    done_clear_a: assert property (
        (tmr_done && q_reg.wel_clear_pend && !q_reg.suspended) |->
            !status_byte[`STAT_BUSY_BIT] ##1 !q_reg.write_latch_flag)
        else $error("busy or latch left set after completion");

    latch_set_a: assert property (
        (exec_now && !busy_now && q_reg.opcode == `OP_LATCH_SET &&
         !(q_reg.reset_armed && q_reg.opcode == RESET_OP)) |=> q_reg.write_latch_flag)
        else $error("latch not set");

    latch_clear_a: assert property (
        (exec_now && !busy_now && q_reg.opcode == LATCH_CLEAR_OP) |=> !q_reg.write_latch_flag)
        else $error("latch not cleared");

    latch_source_a: assert property (
        $rose(q_reg.write_latch_flag) |-> (q_reg.opcode == `OP_LATCH_SET))
        else $error("latch set by another instruction");

    gate_start_a: assert property (
        (q_reg.op_start && q_reg.opcode != `OP_READ_PARAM_VOL &&
         q_reg.opcode != `OP_BANK_ADDR_VOL) |-> $past(q_reg.write_latch_flag))
        else $error("write started without latch");

    status_copy_a: assert property (
        (q_reg.op_start && q_reg.opcode == `OP_STATUS_WRITE) |->
            (q_reg.vol == q_reg.nv) && (q_reg.vol == $past(q_reg.wdata[7:2])))
        else $error("status write did not update both copies");
endmodule : flash_status_write_enable
`default_nettype wire

// ==== rtl/op_timer.sv ====
// Down counter that stands in for an internal array operation.
// Assumes load and abort are single-cycle pulses from the same clock.
`timescale 1ns/1ns
`default_nettype none
module op_timer #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_b,
    // Control
    input  wire logic         load,
    input  wire logic [W-1:0] load_value,
    input  wire logic         pause,
    input  wire logic         abort,
    // State
    output var  logic         busy,
    output var  logic         done
);
    typedef struct packed {
        logic [W-1:0] count;
        logic         done;
    } timer_state_type;

    timer_state_type q_reg;
    timer_state_type q_next;

    if (W < 2) begin : bad_width
        $error("op_timer width must be at least two");
    end

    always_comb begin
        q_next      = q_reg;
        q_next.done = 1'b0;
        if (abort) begin
            q_next.count = '0;
        end else if (load) begin
            q_next.count = load_value;
        end else if (!pause && q_reg.count != '0) begin
            q_next.count = q_reg.count - W'(1);
            q_next.done  = (q_reg.count == W'(1));
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    // Paused counts hold busy so resume continues where it stopped
    assign busy = (q_reg.count != '0);
    assign done = q_reg.done;
endmodule : op_timer
`default_nettype wire

// ==== rtl/pin_sync.sv ====
// Two-stage synchroniser for a group of pins.
// Assumes pins are asynchronous to mclk; first stage feeds only the second.
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int               WIDTH     = 4,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_b,
    // Pins in, synchronised out
    input  wire logic [WIDTH-1:0] pin_in,
    output var  logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_type;

    sync_state_type q_reg;
    sync_state_type q_next;

    if (WIDTH < 1) begin : bad_width
        $error("pin_sync width must be at least one");
    end

    always_comb begin
        q_next.stage1 = pin_in;
        q_next.stage2 = q_reg.stage1;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            q_reg <= {RESET_VAL, RESET_VAL};
        end else begin
            q_reg <= q_next;
        end
    end

    assign sync_out = q_reg.stage2;
endmodule : pin_sync
`default_nettype wire

// ==== tb/flash_host_model.sv ====
// Host controller model: drives the serial pins of the flash block.
// Assumes mode 0 framing; the bench calls frame() between frames.
`timescale 1ns/1ns
`default_nettype none
module flash_host_model (
    // Clock
    input  wire logic mclk,
    // Serial pins
    output var  logic ce_b,
    output var  logic sck,
    output var  logic si,
    input  wire logic so
);
    // Phase length in mclk; three is the legal minimum
    int half = 5;

    initial begin
        ce_b = 1'b1;
        sck  = 1'b0;
        si   = 1'b0;
    end

    // Data bits go out MSB first; nw, nr count bits
    task automatic frame(input logic [7:0] op, input logic [7:0] wd, input int nw,
                         input int nr, output logic [15:0] rd);
        logic [15:0] w;
        w  = {op, wd};
        rd = '0;
        @(posedge mclk);
        #1 ce_b = 1'b0;
        for (int i = 0; i < 8 + nw + nr; i++) begin
            si = (i < 8 + nw) ? w[15 - i] : ~si;
            repeat (half) @(posedge mclk);
            #1 rd = (i < 8 + nw) ? rd : {rd[14:0], so};
            sck = 1'b1;
            repeat (half) @(posedge mclk);
            #1 sck = 1'b0;
        end
        repeat (half) @(posedge mclk);
        #1 ce_b = 1'b1;
        // Released line shows a changed level, not the last bit
        si = ~si;
        repeat (8) @(posedge mclk);
        #1;
    endtask : frame
endmodule : flash_host_model
`default_nettype wire

// ==== tb/flash_status_write_enable_tb.sv ====
// Bench for the status byte and write-enable gating block.
// Assumes the host model file; long counts shortened by parameter.
`timescale 1ns/1ns
`default_nettype none
module flash_status_write_enable_tb;
    import flash_status_pkg::*;
    logic         mclk, rst_b, wp_b, ce_b, sck, si, so, so_oe;
    logic         op_start, op_suspended, quad_pin_enable;
    op_class_type op_kind;
    logic [7:0]   status_byte;
    logic [3:0]   block_protect;
    logic [31:0]  dpd_param_word;
    logic [15:0]  rd;
    int           err_count = 0;
    int           total_checks = 0;
    int           starts = 0;
    // Class in the top nibble: 0 none, 1 program, 2 erase, 3 stored, 4 volatile,
    // 5 volatile that runs without the latch
    logic [11:0]  op_tab [36] = '{12'h102, 12'h112, 12'h132, 12'h138, 12'h134,
        12'h13e, 12'h162, 12'h2d7, 12'h220, 12'h221, 12'h252, 12'h25c, 12'h2d8,
        12'h2dc, 12'h264, 12'h2c7, 12'h260, 12'h342, 12'h365, 12'h385, 12'h315,
        12'h318, 12'h3fd, 12'h3e3, 12'h3e4, 12'h32f, 12'h3a6, 12'h3e8, 12'h37e,
        12'h398, 12'h483, 12'h4fb, 12'h4e1, 12'h491, 12'h5c0, 12'h517};

    flash_status_write_enable #(.PROG_CYCLES(20), .ERASE_CYCLES(800),
        .NVREG_CYCLES(20)) flash_status_write_enable_i (.mclk(mclk), .rst_b(rst_b),
        .ce_b(ce_b), .sck(sck), .si(si), .wp_b(wp_b), .so(so), .so_oe(so_oe),
        .op_start(op_start), .op_kind(op_kind), .op_suspended(op_suspended),
        .status_byte(status_byte), .quad_pin_enable(quad_pin_enable),
        .block_protect(block_protect), .dpd_param_word(dpd_param_word));
    flash_host_model flash_host_model_i (.mclk(mclk), .ce_b(ce_b), .sck(sck),
        .si(si), .so(so));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // Counted mid-cycle, away from the edge that launches the pulse
    always @(negedge mclk) if (op_start === 1'b1) starts++;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : report_and_stop

    task automatic do_reset();
        rst_b = 1'b0;
        repeat (3) @(posedge mclk);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge mclk);
        #1;
    endtask : do_reset

    task automatic cmd(input logic [7:0] op);
        flash_host_model_i.frame(op, 8'h00, 0, 0, rd);
    endtask : cmd

    // Two bytes read in one frame must match
    task automatic rd_stat(input logic [7:0] exp);
        flash_host_model_i.frame(8'h05, 8'h00, 0, 16, rd);
        chk(rd, {exp, exp});
        chk(so_oe, 1'b0);
    endtask : rd_stat

    // Bounded wait; latch clears a cycle after busy drops
    task automatic wait_idle();
        int n;
        n = 0;
        while (status_byte[0] !== 1'b0 && n < 1000) begin
            @(posedge mclk);
            #1 n++;
        end
        if (n == 1000) begin
            err_count++;
            report_and_stop();
        end
        repeat (3) @(posedge mclk);
        #1;
    endtask : wait_idle

    task automatic t_reset();
        chk(status_byte, 8'h00);
        chk(dpd_param_word, {1'b0, 8'hb9, 8'hab, 15'h0000});
        rd_stat(8'h00);
        cmd(8'h06);
        chk(status_byte, 8'h02);
        rd_stat(8'h02);
        cmd(8'h04);
        chk(status_byte, 8'h00);
        $display("test reset_latch done");
    endtask : t_reset

    task automatic t_gate();
        int s0;
        logic [3:0] k;
        logic latch_free;
        foreach (op_tab[i]) begin
            k          = op_tab[i][11:8];
            latch_free = (k == 4'h5);
            s0         = starts;
            cmd(op_tab[i][7:0]);
            chk(starts - s0, latch_free);
            cmd(8'h06);
            cmd(op_tab[i][7:0]);
            chk(starts - s0, latch_free ? 2 : (k != 0));
            if (k != 0) chk(op_kind, latch_free ? 4 : k);
            chk(status_byte[0], k inside {1, 2, 3});
            wait_idle();
            chk(status_byte[1], k inside {0, 4, 5});
            cmd(8'h04);
        end
        $display("test opcode_gate done");
    endtask : t_gate

    task automatic t_busy();
        cmd(8'h06);
        cmd(8'hd8);
        cmd(8'h04);
        rd_stat(8'h03);
        cmd(8'h75);
        chk(op_suspended, 1'b1);
        chk(status_byte[0], 1'b0);
        cmd(8'h7a);
        chk(op_suspended, 1'b0);
        wait_idle();
        chk(status_byte, 8'h00);
        // Soft reset pair is taken while busy and aborts the erase
        cmd(8'h06);
        cmd(8'hd8);
        cmd(8'h66);
        cmd(8'h99);
        chk(status_byte, 8'h00);
        $display("test busy_suspend done");
    endtask : t_busy

    task automatic t_status();
        cmd(8'h06);
        flash_host_model_i.frame(8'h01, 8'hbc, 8, 0, rd);
        chk(status_byte, 8'hbf);
        wait_idle();
        chk(status_byte, 8'hbc);
        chk(block_protect, 4'hf);
        cmd(8'h06);
        cmd(8'hc7);
        chk(status_byte, 8'hbe);
        wp_b = 1'b0;
        flash_host_model_i.frame(8'h01, 8'h00, 8, 0, rd);
        wait_idle();
        chk(status_byte, 8'hbe);
        wp_b = 1'b1;
        flash_host_model_i.frame(8'h01, 8'h40, 8, 0, rd);
        wait_idle();
        chk(status_byte, 8'h40);
        chk(quad_pin_enable, 1'b1);
        do_reset();
        chk(status_byte, 8'h00);
        $display("test status_write done");
    endtask : t_status

    initial begin
        wp_b = 1'b1;
        do_reset();
        t_reset();
        t_gate();
        t_busy();
        t_status();
        report_and_stop();
    end
endmodule : flash_status_write_enable_tb
`default_nettype wire
